/* File: verilog/qsg_status_group.sv */
// qsg_status_group: condition, filter, event latch, mask and summary of the abnormal status group.
// assumes monitor inputs are asynchronous levels and commands are single-cycle on clock.
//
// Operation
// - filtered edges set sticky read-only event bits
// - reading the event register clears it
// - condition register shows live monitor levels
// - mask register writable, 0..32767, resets zero
// - summary bit is OR of masked events
// - falling-edge filter bit passes falling edges
// - rising-edge filter bit passes rising edges
// - both filter bits pass either edge
// - no filter bits, no event
// - filter write may itself set events
// - filters writable, 0..32767, reset zero
// - fixed condition bit map, others zero
// - preset: rise filter 1555, others cleared
// - clear-status command clears event register
`timescale 1ns/1ps
`default_nettype none

module qsg_status_group (
    input  wire logic               clock,
    input  wire logic               rst_b,
    input  wire qsg_pkg::qsg_cond_s monitors,
    input  wire qsg_pkg::qsg_cmd_s  cmd,
    input  wire logic               status_preset_command,
    input  wire logic               clear_status_command,
    output logic [15:0]             rd_data,
    output logic                    rd_valid,
    output logic                    abnormal_summary_bit
);
    import qsg_pkg::*;

    // map monitor levels onto their condition bit weights
    function automatic logic [15:0] cond_vector(input qsg_cond_s m);
        logic [15:0] v;
        v                      = 16'h0000;
        v[QSG_BIT_OVERVOLTAGE] = m.overvoltage_trip;
        v[QSG_BIT_OVERCURRENT] = m.overcurrent_trip;
        v[QSG_BIT_OVERTEMP]    = m.overtemperature_flag;
        v[QSG_BIT_INHIBIT]     = m.remote_inhibit_active;
        v[QSG_BIT_UNREGULATED] = m.output_unregulated;
        return v;
    endfunction

    // true when the command is a write of the given register
    function automatic logic is_write(input qsg_cmd_s c, input qsg_sel_e s);
        return c.valid && c.write && (c.sel == s);
    endfunction

    // true when the command is a read of the given register
    function automatic logic is_read(input qsg_cmd_s c, input qsg_sel_e s);
        return c.valid && !c.write && (c.sel == s);
    endfunction

    qsg_state_s  st_r;
    qsg_state_s  st_nxt;
    logic [15:0] rise_w;
    logic [15:0] fall_w;
    logic [15:0] set_w;
    logic        ev_clear_w;
    logic        filt_wr_w;

    // edges of the synchronised conditions against the previous clock
    assign rise_w     = st_r.sync2 & ~st_r.cond_prev;
    assign fall_w     = ~st_r.sync2 & st_r.cond_prev;
    assign ev_clear_w = is_read(cmd, QSG_SEL_EVENT) || clear_status_command;
    assign filt_wr_w  = is_write(cmd, QSG_SEL_RISE_FILTER) || is_write(cmd, QSG_SEL_FALL_FILTER)
                        || status_preset_command;

    // next state: filters, mask, event latch, read data and summary
    always_comb begin
        logic [15:0] new_rise;
        logic [15:0] new_fall;
        logic [15:0] filt_set;
        new_rise = st_r.rise_filter;
        new_fall = st_r.fall_filter;
        filt_set = 16'h0000;
        st_nxt   = st_r;

        // two-flop synchroniser then previous-value register
        st_nxt.sync1     = cond_vector(monitors);
        st_nxt.sync2     = st_r.sync1;
        st_nxt.cond_prev = st_r.sync2;

        // host writes of the writable registers, bit 15 held zero
        if (is_write(cmd, QSG_SEL_MASK)) begin
            st_nxt.summary_mask = cmd.wdata & QSG_VALUE_MASK;
        end
        if (is_write(cmd, QSG_SEL_RISE_FILTER)) begin
            new_rise = cmd.wdata & QSG_VALUE_MASK;
        end
        if (is_write(cmd, QSG_SEL_FALL_FILTER)) begin
            new_fall = cmd.wdata & QSG_VALUE_MASK;
        end

        // preset overrides a write in the same cycle
        if (status_preset_command) begin
            new_rise            = QSG_PRESET_RISE;
            new_fall            = QSG_PRESET_CLEAR;
            st_nxt.summary_mask = QSG_PRESET_CLEAR;
        end
        st_nxt.rise_filter = new_rise;
        st_nxt.fall_filter = new_fall;

        // newly enabled filter bits act as if the edge into the present level occurred
        filt_set = (new_rise & ~st_r.rise_filter & st_r.sync2)
                 | (new_fall & ~st_r.fall_filter & ~st_r.sync2);

        // event latch: sticky, read or clear-status clears, set wins
        if (ev_clear_w) begin
            st_nxt.event_latch = 16'h0000;
        end
        st_nxt.event_latch = st_nxt.event_latch | set_w | filt_set;

        // register read returns the value before any clear
        st_nxt.rd_valid = cmd.valid && !cmd.write;
        st_nxt.rd_data  = st_r.rd_data;
        if (cmd.valid && !cmd.write) begin
            unique case (cmd.sel)
                QSG_SEL_CONDITION:   st_nxt.rd_data = st_r.sync2;
                QSG_SEL_EVENT:       st_nxt.rd_data = st_r.event_latch;
                QSG_SEL_MASK:        st_nxt.rd_data = st_r.summary_mask;
                QSG_SEL_FALL_FILTER: st_nxt.rd_data = st_r.fall_filter;
                QSG_SEL_RISE_FILTER: st_nxt.rd_data = st_r.rise_filter;
                default:             st_nxt.rd_data = 16'h0000;
            endcase
        end

        // summary follows the registered event and mask one cycle later
        st_nxt.summary = |(st_r.event_latch & st_r.summary_mask);
    end

    // edge filter: each direction passes only where its filter bit is one
    assign set_w = (rise_w & st_r.rise_filter) | (fall_w & st_r.fall_filter);

    // state register with synchronous reset
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from flip-flops
    assign rd_data              = st_r.rd_data;
    assign rd_valid             = st_r.rd_valid;
    assign abnormal_summary_bit = st_r.summary;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);

    // a passed rising edge lands in the event latch
    chk_rise_sets_event: assert property ((|(rise_w & st_r.rise_filter))
        |=> ((st_r.event_latch & $past(rise_w & st_r.rise_filter)) == $past(rise_w & st_r.rise_filter)))
        else $error("rising edge not latched");

    // a passed falling edge lands in the event latch
    chk_fall_sets_event: assert property ((|(fall_w & st_r.fall_filter))
        |=> ((st_r.event_latch & $past(fall_w & st_r.fall_filter)) == $past(fall_w & st_r.fall_filter)))
        else $error("falling edge not latched");

    // without a filter bit and a filter write no event bit appears
    chk_no_filter_quiet: assert property (!filt_wr_w
        |=> ((st_r.event_latch & ~$past(st_r.event_latch) & ~$past(st_r.rise_filter | st_r.fall_filter)) == 16'h0000))
        else $error("event set without filter");

    // event bits stay set until a read or clear-status
    chk_event_sticky: assert property (!ev_clear_w
        |=> ((st_r.event_latch & $past(st_r.event_latch)) == $past(st_r.event_latch)))
        else $error("event bit lost without clear");

    // read of the event register returns it, then only new sets remain
    chk_event_read_clr: assert property (is_read(cmd, QSG_SEL_EVENT) && (set_w == 16'h0000)
        && !filt_wr_w |=> rd_valid && (rd_data == $past(st_r.event_latch)) && (st_r.event_latch == 16'h0000))
        else $error("event read did not clear");

    // condition read shows the live synchronised levels in the mapped bits only
    chk_cond_live: assert property (is_read(cmd, QSG_SEL_CONDITION)
        |=> (rd_data == $past(st_r.sync2)) && ((rd_data & ~QSG_PRESET_RISE) == 16'h0000))
        else $error("condition read wrong");

    // preset loads the filters and mask
    chk_preset_vals: assert property (status_preset_command
        |=> (st_r.rise_filter == QSG_PRESET_RISE) && (st_r.fall_filter == 16'h0000)
            && (st_r.summary_mask == 16'h0000))
        else $error("preset values wrong");

    // a set in the same cycle as a clear survives
    chk_set_wins: assert property (ev_clear_w && (set_w != 16'h0000)
        |=> ((st_r.event_latch & $past(set_w)) == $past(set_w)))
        else $error("clear beat a set");

    // summary is the masked OR one cycle later
    chk_summary_or: assert property (##1 abnormal_summary_bit
        == |($past(st_r.event_latch) & $past(st_r.summary_mask)))
        else $error("summary bit wrong");

    // writable registers never hold bit 15
    chk_value_range: assert property (!st_r.summary_mask[15] && !st_r.rise_filter[15]
        && !st_r.fall_filter[15])
        else $error("register out of range");

    // first synchroniser stage takes the mapped monitor levels
    chk_sync_path: assert property ($past(rst_b)
        |-> (st_r.sync1 == $past(cond_vector(monitors))))
        else $error("synchroniser input wrong");

    // unmapped condition positions stay zero all the way through
    chk_cond_spare_zero: assert property ((st_r.sync2 & ~cond_vector('1)) == 16'h0000)
        else $error("unmapped condition bit set");

    // previous-value register trails the synchronised condition by one clock
    chk_prev_trails: assert property ($past(rst_b)
        |-> (st_r.cond_prev == $past(st_r.sync2)))
        else $error("previous condition not tracked");

    // a mask write lands with bit 15 dropped, unless a preset wins
    chk_mask_write: assert property (is_write(cmd, QSG_SEL_MASK) && !status_preset_command
        |=> (st_r.summary_mask == $past(cmd.wdata & QSG_VALUE_MASK)))
        else $error("mask write lost");

    // a rise filter write lands with bit 15 dropped, unless a preset wins
    chk_rise_write: assert property (is_write(cmd, QSG_SEL_RISE_FILTER) && !status_preset_command
        |=> (st_r.rise_filter == $past(cmd.wdata & QSG_VALUE_MASK)))
        else $error("rise filter write lost");

    // a fall filter write lands with bit 15 dropped, unless a preset wins
    chk_fall_write: assert property (is_write(cmd, QSG_SEL_FALL_FILTER) && !status_preset_command
        |=> (st_r.fall_filter == $past(cmd.wdata & QSG_VALUE_MASK)))
        else $error("fall filter write lost");

    // a write aimed at the event register changes nothing by itself
    chk_event_no_write: assert property (is_write(cmd, QSG_SEL_EVENT) && (set_w == 16'h0000)
        && !clear_status_command && !status_preset_command |=> $stable(st_r.event_latch))
        else $error("event register took a write");

    // clear-status leaves only the sets of its own cycle
    chk_clear_status: assert property (clear_status_command && !filt_wr_w
        |=> (st_r.event_latch == $past(set_w)))
        else $error("clear-status left events");

    // each read answers with exactly one valid pulse
    chk_read_pulse: assert property ($past(rst_b)
        |-> (rd_valid == $past(cmd.valid && !cmd.write)))
        else $error("read valid pulse wrong");

    // read data stands until the next read
    chk_rd_hold: assert property ($past(rst_b) && !$past(cmd.valid && !cmd.write)
        |-> $stable(rd_data))
        else $error("read data changed without a read");

    // mask read returns the stored mask
    chk_mask_read: assert property (is_read(cmd, QSG_SEL_MASK)
        |=> (rd_data == $past(st_r.summary_mask)))
        else $error("mask read wrong");

    // rise filter read returns the stored filter
    chk_rise_read: assert property (is_read(cmd, QSG_SEL_RISE_FILTER)
        |=> (rd_data == $past(st_r.rise_filter)))
        else $error("rise filter read wrong");

    // fall filter read returns the stored filter
    chk_fall_read: assert property (is_read(cmd, QSG_SEL_FALL_FILTER)
        |=> (rd_data == $past(st_r.fall_filter)))
        else $error("fall filter read wrong");

    // a rise filter write sets newly passed bits whose condition is high
    chk_rise_wr_sets: assert property (is_write(cmd, QSG_SEL_RISE_FILTER) && !status_preset_command
        |=> ((st_r.event_latch & $past(cmd.wdata & QSG_VALUE_MASK & ~st_r.rise_filter & st_r.sync2))
            == $past(cmd.wdata & QSG_VALUE_MASK & ~st_r.rise_filter & st_r.sync2)))
        else $error("rise filter write set nothing");

    // a fall filter write sets newly passed bits whose condition is low
    chk_fall_wr_sets: assert property (is_write(cmd, QSG_SEL_FALL_FILTER) && !status_preset_command
        |=> ((st_r.event_latch & $past(cmd.wdata & QSG_VALUE_MASK & ~st_r.fall_filter & ~st_r.sync2))
            == $past(cmd.wdata & QSG_VALUE_MASK & ~st_r.fall_filter & ~st_r.sync2)))
        else $error("fall filter write set nothing");

    // with both filter bits either edge of the condition lands
    chk_both_edges: assert property (|((rise_w | fall_w) & st_r.rise_filter & st_r.fall_filter)
        |=> ((st_r.event_latch & $past((rise_w | fall_w) & st_r.rise_filter & st_r.fall_filter))
            == $past((rise_w | fall_w) & st_r.rise_filter & st_r.fall_filter)))
        else $error("edge lost with both filters");

    // an empty mask keeps the summary low
    chk_summary_masked_off: assert property ((st_r.summary_mask == 16'h0000)
        |=> !abnormal_summary_bit)
        else $error("summary set with empty mask");

    // clearing rise filter bits sets no event
    chk_rise_clr_quiet: assert property (is_write(cmd, QSG_SEL_RISE_FILTER)
        && ((cmd.wdata & ~st_r.rise_filter) == 16'h0000) && (set_w == 16'h0000) && !status_preset_command
        |=> ((st_r.event_latch & ~$past(st_r.event_latch)) == 16'h0000))
        else $error("rise filter clear set an event");

    // clearing fall filter bits sets no event
    chk_fall_clr_quiet: assert property (is_write(cmd, QSG_SEL_FALL_FILTER)
        && ((cmd.wdata & ~st_r.fall_filter) == 16'h0000) && (set_w == 16'h0000) && !status_preset_command
        |=> ((st_r.event_latch & ~$past(st_r.event_latch)) == 16'h0000))
        else $error("fall filter clear set an event");

endmodule // qsg_status_group

`default_nettype wire

/* File: verilog/qsg_pkg.sv */
// qsg_pkg: constants, register selects and carriers for the abnormal status group.
// assumes a command interpreter on the same clock issues register accesses.
`default_nettype none

package qsg_pkg;

    // register width and legal value range (0 to 32767)
    localparam int          QSG_W          = 16;
    localparam logic [15:0] QSG_VALUE_MASK = 16'h7FFF;

    // condition bit positions
    localparam int QSG_BIT_OVERVOLTAGE = 0;
    localparam int QSG_BIT_OVERCURRENT = 1;
    localparam int QSG_BIT_OVERTEMP    = 4;
    localparam int QSG_BIT_INHIBIT     = 9;
    localparam int QSG_BIT_UNREGULATED = 10;

    // position of the summary bit inside the status byte
    localparam int QSG_SUMMARY_BIT_POS = 3;

    // reset and preset values
    localparam logic [15:0] QSG_RESET_VALUE  = 16'h0000;
    localparam logic [15:0] QSG_PRESET_RISE  = 16'h0613;
    localparam logic [15:0] QSG_PRESET_CLEAR = 16'h0000;

    // register selected by a command
    typedef enum logic [2:0] {
        QSG_SEL_CONDITION,
        QSG_SEL_EVENT,
        QSG_SEL_MASK,
        QSG_SEL_FALL_FILTER,
        QSG_SEL_RISE_FILTER
    } qsg_sel_e;

    // one register access from the command interpreter
    typedef struct packed {
        logic          valid;
        logic          write;
        qsg_sel_e      sel;
        logic [15:0]   wdata;
    } qsg_cmd_s;

    // live protection and inhibit monitor levels
    typedef struct packed {
        logic overvoltage_trip;
        logic overcurrent_trip;
        logic overtemperature_flag;
        logic remote_inhibit_active;
        logic output_unregulated;
    } qsg_cond_s;

    // the whole block state
    typedef struct packed {
        logic [15:0] sync1;
        logic [15:0] sync2;
        logic [15:0] cond_prev;
        logic [15:0] event_latch;
        logic [15:0] summary_mask;
        logic [15:0] fall_filter;
        logic [15:0] rise_filter;
        logic [15:0] rd_data;
        logic        rd_valid;
        logic        summary;
    } qsg_state_s;

endpackage : qsg_pkg

`default_nettype wire

/* File: dv/qsg_monitor_model.sv */
// qsg_monitor_model: protection monitors and status byte collector around the status group.
// assumes the bench gives monitor levels as a condition-weighted word, changed at falling edges.
`timescale 1ns/1ps
`default_nettype none

module qsg_monitor_model (
    input  wire logic             clock,
    input  wire logic [15:0]      trip_req,
    input  wire logic             summary,
    output var qsg_pkg::qsg_cond_s monitors,
    output logic [7:0]            status_byte
);
    import qsg_pkg::*;

    // drive each monitor line from its weight in the request word
    always_comb begin
        monitors.overvoltage_trip      = trip_req[QSG_BIT_OVERVOLTAGE];
        monitors.overcurrent_trip      = trip_req[QSG_BIT_OVERCURRENT];
        monitors.overtemperature_flag  = trip_req[QSG_BIT_OVERTEMP];
        monitors.remote_inhibit_active = trip_req[QSG_BIT_INHIBIT];
        monitors.output_unregulated    = trip_req[QSG_BIT_UNREGULATED];
    end

    // status byte keeps only the summary bit of this group
    always_ff @(posedge clock) begin
        status_byte <= 8'(summary) << QSG_SUMMARY_BIT_POS;
    end
endmodule // qsg_monitor_model

`default_nettype wire

/* File: dv/questionable_status_group_tb.sv */
// questionable_status_group_tb: register access tests of the abnormal status group.
// assumes the monitor model beside the design; all stimulus changes on falling edges.
`timescale 1ns/1ps
`default_nettype none

module questionable_status_group_tb;
    import qsg_pkg::*;

    logic       clock;
    logic       rst_b;
    qsg_cmd_s   cmd;
    qsg_cond_s  monitors;
    logic       preset;
    logic       clr;
    logic [15:0] trip;
    logic [15:0] rd_data;
    logic       rd_valid;
    logic       summary;
    logic [7:0] sbyte;
    int         error_cnt;
    int         checked;

    // 40 ns clock
    always #20 clock = ~clock;

    qsg_status_group u_qsg_status_group (
        .clock                 (clock),
        .rst_b                 (rst_b),
        .monitors              (monitors),
        .cmd                   (cmd),
        .status_preset_command (preset),
        .clear_status_command  (clr),
        .rd_data               (rd_data),
        .rd_valid              (rd_valid),
        .abnormal_summary_bit  (summary)
    );

    qsg_monitor_model u_qsg_monitor_model (
        .clock       (clock),
        .trip_req    (trip),
        .summary     (summary),
        .monitors    (monitors),
        .status_byte (sbyte)
    );

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one register access, held for one rising edge
    task automatic acc(input logic wr, input qsg_sel_e s, input logic [15:0] d);
        @(negedge clock) cmd <= '{1'b1, wr, s, d};
        @(negedge clock) cmd <= '0;
    endtask

    // read and compare; a missing rd_valid pulse shows as a mismatch
    task automatic rd(input qsg_sel_e s, input logic [15:0] exp, input string nm);
        acc(1'b0, s, 16'h0000);
        chk(nm, (rd_valid === 1'b1) ? rd_data : 16'hDEAD, exp);
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge clock);
    endtask

    task automatic stop_test;
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // watchdog far beyond the roughly 180 cycles of the tests
    initial begin
        repeat (3000) @(posedge clock);
        error_cnt++;
        stop_test();
    end

    // main sequence
    initial begin
        clock = 0; rst_b = 0; cmd = '0; trip = '0; preset = 0; clr = 0;
        error_cnt = 0; checked = 0;
        repeat (12) @(negedge clock);
        rst_b <= 1;
        rd(QSG_SEL_MASK, 16'h0000, "mask_rst");
        rd(QSG_SEL_FALL_FILTER, 16'h0000, "fall_rst");
        rd(QSG_SEL_RISE_FILTER, 16'h0000, "rise_rst");
        acc(1'b1, QSG_SEL_MASK, 16'hFFFF);
        rd(QSG_SEL_MASK, 16'h7FFF, "mask_wr");
        acc(1'b1, QSG_SEL_EVENT, 16'hFFFF);
        rd(QSG_SEL_EVENT, 16'h0000, "event_ro");
        // every filter combination, rise then fall of all monitors
        for (int m = 0; m < 4; m++) begin
            acc(1'b1, QSG_SEL_RISE_FILTER, m[0] ? 16'h7FFF : 16'h0000);
            acc(1'b1, QSG_SEL_FALL_FILTER, m[1] ? 16'h7FFF : 16'h0000);
            idle(2);
            acc(1'b0, QSG_SEL_EVENT, 16'h0000);
            trip <= 16'hFFFF;
            idle(5);
            rd(QSG_SEL_CONDITION, 16'h0613, "cond");
            chk("summary", {15'h0, sbyte[3]}, {15'h0, m[0]});
            rd(QSG_SEL_EVENT, m[0] ? 16'h0613 : 16'h0000, "rise_evt");
            rd(QSG_SEL_EVENT, 16'h0000, "evt_clr");
            trip <= 16'h0000;
            idle(5);
            rd(QSG_SEL_EVENT, m[1] ? 16'h0613 : 16'h0000, "fall_evt");
        end
        // filter write alone sets events for the standing condition
        acc(1'b1, QSG_SEL_RISE_FILTER, 16'h0000);
        acc(1'b1, QSG_SEL_FALL_FILTER, 16'h0000);
        trip <= 16'hFFFF;
        idle(5);
        rd(QSG_SEL_EVENT, 16'h0000, "no_filter");
        acc(1'b1, QSG_SEL_RISE_FILTER, 16'h0010);
        rd(QSG_SEL_EVENT, 16'h0010, "filter_wr");
        acc(1'b1, QSG_SEL_RISE_FILTER, 16'h0011);
        @(negedge clock) clr <= 1;
        @(negedge clock) clr <= 0;
        rd(QSG_SEL_EVENT, 16'h0000, "clear_status");
        @(negedge clock) preset <= 1;
        @(negedge clock) preset <= 0;
        rd(QSG_SEL_RISE_FILTER, 16'h0613, "preset_rise");
        rd(QSG_SEL_FALL_FILTER, 16'h0000, "preset_fall");
        rd(QSG_SEL_MASK, 16'h0000, "preset_mask");
        rd(QSG_SEL_EVENT, 16'h0602, "preset_evt");
        // an event read taken on the edge that latches a rise keeps the new bits
        trip <= 16'h0000;
        idle(5);
        trip <= 16'hFFFF;
        idle(1);
        rd(QSG_SEL_EVENT, 16'h0000, "set_clr_old");
        rd(QSG_SEL_EVENT, 16'h0613, "set_wins");
        // single monitors land on their own weights; a new fall filter bit fires on a low condition
        trip <= 16'h0412;
        idle(3);
        rd(QSG_SEL_CONDITION, 16'h0412, "cond_map");
        acc(1'b1, QSG_SEL_FALL_FILTER, 16'h0003);
        rd(QSG_SEL_EVENT, 16'h0001, "fall_filter_wr");
        stop_test();
    end
endmodule // questionable_status_group_tb

`default_nettype wire
